// file: ied_align_chk.sv
// alignment checker for one address against an access size
// assumes size codes from ied_pkg; purely combinational
`timescale 1ns/100ps
module ied_align_chk (
    input  wire logic [1:0] addr_lo,
    input  wire logic [1:0] acc_size,
    output logic            misaligned
);

    // ------------------------------------------------------------
    // width decode
    // ------------------------------------------------------------
    wire logic is_half;
    wire logic is_word;

    assign is_half    = (acc_size == ied_pkg::ACC_SIZE_HALF);
    assign is_word    = (acc_size == ied_pkg::ACC_SIZE_WORD);
    // byte accesses never fault
    assign misaligned = (is_word && (addr_lo != 2'h0)) || (is_half && addr_lo[0]);

endmodule : ied_align_chk

// file: ied_exception_detect.sv
// instruction-related exception detection and classification
// assumes decoder, mmu/mpu lookups and status bits arrive on core_clk with
// the issued instruction; the sequencer consumes the one-cycle result
// Functional notes
// - trap instruction raises software trap, general handler
// - break instruction raises break exception, break handler
// - valid but unbuilt instruction raises unimplemented instruction exception
// - undefined opcode raises illegal when checking on; forced with mmu/mpu
// - internally reserved encodings never raise illegal instruction
// - user mode with mmu/mpu: six privileged ops raise supervisor instruction
// - user mode with mmu: supervisor fetch address raises exception
// - user mode with mmu: load, store, address flush to supervisor data
// - data misalign checking forced with mmu/mpu, optional otherwise
// - word needs multiple of four, half multiple of two, bytes fine
// - jump, call, return, resume and branch targets need multiple of four
// - destination misalign checking forced with mmu/mpu, optional otherwise
// - with divider and enable: zero divisor or most-negative by minus one
// - tlb miss with handling flag clear sets flag, fast miss handler
// - fast miss kind instruction or data recorded in miss kind flag
// - tlb miss with handling flag set: double miss, keep regs, general
// - double miss kind reported in reason field and miss kind flag
// - matched entry forbidding access: execute, read or write violation
// - data cache management ops skip tlb permission checks
// - with mpu: no region match or forbidden region raises violation
// - mpu violation classed instruction or data in reason field
// - noninterrupt exception handlers always use the normal register set
`timescale 1ns/100ps
module ied_exception_detect (
    input  wire logic        core_clk,
    input  wire logic        reset,
    // build configuration
    input  wire logic        cfg_mmu_present,
    input  wire logic        cfg_mpu_present,
    input  wire logic        cfg_illegal_check_en,
    input  wire logic        cfg_misalign_data_en,
    input  wire logic        cfg_misalign_dest_en,
    input  wire logic        cfg_div_check_en,
    input  wire logic        cfg_hw_divider,
    // status bits
    input  wire logic        user_mode_flag,
    input  wire logic        exception_handling_flag,
    // issued instruction
    input  wire logic        issue_valid,
    input  wire logic        op_trap,
    input  wire logic        op_break,
    input  wire logic        op_unimpl,
    input  wire logic        op_undefined,
    input  wire logic        op_internal_reserved,
    input  wire logic        op_supervisor_only,
    input  wire logic        op_dcache_mgmt,
    input  wire logic        is_load,
    input  wire logic        is_store,
    input  wire logic        is_addr_init,
    input  wire logic        is_addr_flush,
    input  wire logic [1:0]  access_size,
    input  wire logic [31:0] data_addr,
    input  wire logic        is_ctrl_xfer,
    input  wire logic [31:0] target_addr,
    input  wire logic        is_divide,
    input  wire logic        div_signed,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    // fetch lookups for the issued instruction
    input  wire logic        fetch_super_only,
    input  wire logic        fetch_tlb_hit,
    input  wire logic        fetch_tlb_exec_ok,
    input  wire logic        fetch_mpu_hit,
    input  wire logic        fetch_mpu_perm_ok,
    // data lookups for the issued instruction
    input  wire logic        data_super_only,
    input  wire logic        data_tlb_hit,
    input  wire logic        data_tlb_read_ok,
    input  wire logic        data_tlb_write_ok,
    input  wire logic        data_mpu_hit,
    input  wire logic        data_mpu_perm_ok,
    // result to the exception sequencer
    output logic             exc_valid,
    output ied_pkg::ied_cause_t fault_reason_field,
    output ied_pkg::ied_vec_t   exc_vector,
    output logic             miss_kind_data_flag,
    output logic             eh_set,
    output logic             keep_exc_regs,
    output logic             use_normal_regset
);

    // ------------------------------------------------------------
    // check enables
    // ------------------------------------------------------------
    wire logic prot_unit;
    wire logic illegal_on;
    wire logic mis_data_on;
    wire logic mis_dest_on;
    wire logic div_on;

    assign prot_unit   = cfg_mmu_present || cfg_mpu_present;
    assign illegal_on  = prot_unit || cfg_illegal_check_en;
    assign mis_data_on = prot_unit || cfg_misalign_data_en;
    assign mis_dest_on = prot_unit || cfg_misalign_dest_en;
    assign div_on      = cfg_div_check_en && cfg_hw_divider;

    // ------------------------------------------------------------
    // access classes
    // ------------------------------------------------------------
    wire logic ld_st;
    wire logic data_lookup;
    wire logic super_data_op;

    assign ld_st         = is_load || is_store;
    assign data_lookup   = ld_st || is_addr_init || is_addr_flush;
    assign super_data_op = ld_st || is_addr_flush;

    // ------------------------------------------------------------
    // alignment
    // ------------------------------------------------------------
    logic data_mis_raw;
    logic dest_mis_raw;

    ied_align_chk u_data_align (
        .addr_lo    (data_addr[1:0]),
        .acc_size   (access_size),
        .misaligned (data_mis_raw)
    );

    ied_align_chk u_dest_align (
        .addr_lo    (target_addr[1:0]),
        .acc_size   (ied_pkg::ACC_SIZE_WORD),
        .misaligned (dest_mis_raw)
    );

    // ------------------------------------------------------------
    // individual detections
    // ------------------------------------------------------------
    wire logic det_super_iaddr;
    wire logic fetch_miss;
    wire logic det_perm_exec;
    wire logic det_mpu_instr;
    wire logic det_super_instr;
    wire logic det_illegal;
    wire logic det_mis_dest;
    wire logic det_div;
    wire logic det_mis_data;
    wire logic det_super_daddr;
    wire logic data_miss;
    wire logic perm_checked;
    wire logic det_perm_read;
    wire logic det_perm_write;
    wire logic det_mpu_data;
    wire logic div_ovf;

    assign det_super_iaddr = cfg_mmu_present && user_mode_flag && fetch_super_only;
    assign fetch_miss      = cfg_mmu_present && !fetch_tlb_hit;
    assign det_perm_exec   = cfg_mmu_present && fetch_tlb_hit && !fetch_tlb_exec_ok;
    assign det_mpu_instr   = cfg_mpu_present && !(fetch_mpu_hit && fetch_mpu_perm_ok);
    assign det_super_instr = prot_unit && user_mode_flag && op_supervisor_only;
    assign det_illegal     = illegal_on && op_undefined && !op_internal_reserved;
    assign det_mis_dest    = mis_dest_on && is_ctrl_xfer && dest_mis_raw;
    assign div_ovf         = div_signed && (dividend == ied_pkg::DIV_MOST_NEG)
                             && (divisor == ied_pkg::DIV_MINUS_ONE);
    assign det_div         = div_on && is_divide && ((divisor == ied_pkg::DIV_ZERO) || div_ovf);
    assign det_mis_data    = mis_data_on && ld_st && data_mis_raw;
    assign det_super_daddr = cfg_mmu_present && user_mode_flag && super_data_op
                             && data_super_only;
    assign data_miss       = cfg_mmu_present && data_lookup && !data_tlb_hit;
    // cache management ops never see read or write permission faults
    assign perm_checked    = cfg_mmu_present && data_tlb_hit && !op_dcache_mgmt;
    assign det_perm_read   = perm_checked && is_load && !data_tlb_read_ok;
    assign det_perm_write  = perm_checked && is_store && !data_tlb_write_ok;
    assign det_mpu_data    = cfg_mpu_present && data_lookup
                             && !(data_mpu_hit && data_mpu_perm_ok);

    // ------------------------------------------------------------
    // priority selection: fetch faults, decode, then data faults
    // ------------------------------------------------------------
    ied_pkg::ied_cause_t cause_sel;
    wire logic           any_miss;
    wire logic           miss_is_data;
    wire logic           fast_miss;

    assign miss_is_data = !fetch_miss;
    assign any_miss     = (cause_sel == ied_pkg::CAUSE_FTLB_INSTR)
                          || (cause_sel == ied_pkg::CAUSE_FTLB_DATA)
                          || (cause_sel == ied_pkg::CAUSE_DTLB_INSTR)
                          || (cause_sel == ied_pkg::CAUSE_DTLB_DATA);
    assign fast_miss    = any_miss && !exception_handling_flag;

    assign cause_sel =
        !issue_valid    ? ied_pkg::CAUSE_NONE :
        det_super_iaddr ? ied_pkg::CAUSE_SUPER_IADDR :
        fetch_miss      ? (exception_handling_flag ? ied_pkg::CAUSE_DTLB_INSTR
                                                   : ied_pkg::CAUSE_FTLB_INSTR) :
        det_perm_exec   ? ied_pkg::CAUSE_PERM_EXEC :
        det_mpu_instr   ? ied_pkg::CAUSE_MPU_INSTR :
        det_super_instr ? ied_pkg::CAUSE_SUPER_INSTR :
        det_illegal     ? ied_pkg::CAUSE_ILLEGAL :
        op_unimpl       ? ied_pkg::CAUSE_UNIMPL :
        op_trap         ? ied_pkg::CAUSE_TRAP :
        op_break        ? ied_pkg::CAUSE_BREAK :
        det_mis_dest    ? ied_pkg::CAUSE_MIS_DEST :
        det_div         ? ied_pkg::CAUSE_DIV_ERR :
        det_mis_data    ? ied_pkg::CAUSE_MIS_DATA :
        det_super_daddr ? ied_pkg::CAUSE_SUPER_DADDR :
        data_miss       ? (exception_handling_flag ? ied_pkg::CAUSE_DTLB_DATA
                                                   : ied_pkg::CAUSE_FTLB_DATA) :
        det_perm_read   ? ied_pkg::CAUSE_PERM_READ :
        det_perm_write  ? ied_pkg::CAUSE_PERM_WRITE :
        det_mpu_data    ? ied_pkg::CAUSE_MPU_DATA :
                          ied_pkg::CAUSE_NONE;

    ied_pkg::ied_vec_t vec_sel;
    wire logic         exc_hit;

    assign exc_hit = (cause_sel != ied_pkg::CAUSE_NONE);
    assign vec_sel = (cause_sel == ied_pkg::CAUSE_BREAK) ? ied_pkg::VEC_BREAK :
                     fast_miss ? ied_pkg::VEC_FAST_TLB :
                                 ied_pkg::VEC_GENERAL;

    // ------------------------------------------------------------
    // registered result, one cycle after issue
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            exc_valid           <= ied_pkg::RST_EXC_VALID;
            fault_reason_field  <= ied_pkg::CAUSE_NONE;
            exc_vector          <= ied_pkg::VEC_GENERAL;
            miss_kind_data_flag <= ied_pkg::RST_FLAG;
            eh_set              <= ied_pkg::RST_FLAG;
            keep_exc_regs       <= ied_pkg::RST_FLAG;
            use_normal_regset   <= ied_pkg::RST_FLAG;
        end else begin
            exc_valid           <= exc_hit;
            fault_reason_field  <= cause_sel;
            exc_vector          <= vec_sel;
            // kind flag only moves on a miss, so software sees the last one
            if (any_miss) begin
                miss_kind_data_flag <= miss_is_data;
            end
            eh_set              <= fast_miss;
            keep_exc_regs       <= exc_hit && exception_handling_flag;
            use_normal_regset   <= exc_hit;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking ast_cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_TRAP_GENERAL:
        assert property (fault_reason_field == ied_pkg::CAUSE_TRAP
                         |-> exc_vector == ied_pkg::VEC_GENERAL && $past(op_trap))
        else $error("trap not routed to general handler");
    AST_BREAK_VECTOR:
        assert property ((fault_reason_field == ied_pkg::CAUSE_BREAK)
                         == (exc_valid && exc_vector == ied_pkg::VEC_BREAK))
        else $error("break vector mismatch");
    AST_UNIMPL_CAUSE:
        assert property (fault_reason_field == ied_pkg::CAUSE_UNIMPL |-> $past(op_unimpl))
        else $error("unimplemented raised without cause");
    AST_ILLEGAL_GATED:
        assert property (fault_reason_field == ied_pkg::CAUSE_ILLEGAL
                         |-> $past(illegal_on && op_undefined))
        else $error("illegal raised with checking off");
    AST_RESERVED_QUIET:
        assert property (issue_valid && op_internal_reserved
                         |=> fault_reason_field != ied_pkg::CAUSE_ILLEGAL)
        else $error("reserved encoding raised illegal");
    AST_SUPER_INSTR:
        assert property (fault_reason_field == ied_pkg::CAUSE_SUPER_INSTR
                         |-> $past(user_mode_flag && prot_unit))
        else $error("supervisor instruction fault outside user mode");
    AST_SUPER_IADDR:
        assert property (fault_reason_field == ied_pkg::CAUSE_SUPER_IADDR
                         |-> $past(cfg_mmu_present && user_mode_flag))
        else $error("supervisor fetch fault without mmu");
    AST_MIS_DATA_SIZE:
        assert property (fault_reason_field == ied_pkg::CAUSE_MIS_DATA
                         |-> $past(access_size) != ied_pkg::ACC_SIZE_BYTE)
        else $error("byte access flagged misaligned");
    AST_DIV_CAUSE:
        assert property (fault_reason_field == ied_pkg::CAUSE_DIV_ERR
                         |-> $past(cfg_hw_divider && cfg_div_check_en && is_divide))
        else $error("division error without divider");
    AST_FAST_MISS:
        assert property (exc_valid && exc_vector == ied_pkg::VEC_FAST_TLB
                         |-> eh_set && !$past(exception_handling_flag))
        else $error("fast miss without setting handling flag");
    AST_DOUBLE_MISS:
        assert property (fault_reason_field == ied_pkg::CAUSE_DTLB_DATA
                         |-> keep_exc_regs && exc_vector == ied_pkg::VEC_GENERAL
                             && miss_kind_data_flag)
        else $error("double miss not kept or not general");
    AST_PERM_DCACHE:
        assert property (fault_reason_field == ied_pkg::CAUSE_PERM_READ
                         || fault_reason_field == ied_pkg::CAUSE_PERM_WRITE
                         |-> !$past(op_dcache_mgmt))
        else $error("cache management op took permission fault");
    AST_NORMAL_SET:
        assert property (exc_valid |-> use_normal_regset)
        else $error("exception without normal register set");

    COV_FAST_THEN_DOUBLE:
        cover property (eh_set ##[1:8] fault_reason_field == ied_pkg::CAUSE_DTLB_INSTR);
    COV_MIS_DEST:
        cover property (fault_reason_field == ied_pkg::CAUSE_MIS_DEST);
    COV_MPU_DATA:
        cover property (fault_reason_field == ied_pkg::CAUSE_MPU_DATA);
    COV_BACK_TO_BACK:
        cover property (exc_valid ##1 exc_valid);

endmodule : ied_exception_detect

// file: ied_pkg.sv
// constants and types shared by the instruction exception detector
// assumes one processor clock; all inputs come from same-clock pipeline logic
package ied_pkg;

    // ------------------------------------------------------------
    // access sizes presented with a load or store
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_SIZE_BYTE = 2'h0;
    localparam logic [1:0] ACC_SIZE_HALF = 2'h1;
    localparam logic [1:0] ACC_SIZE_WORD = 2'h2;

    // ------------------------------------------------------------
    // operand values that make a signed divide unrepresentable
    // ------------------------------------------------------------
    localparam logic [31:0] DIV_MOST_NEG  = 32'h8000_0000;
    localparam logic [31:0] DIV_MINUS_ONE = 32'hFFFF_FFFF;
    localparam logic [31:0] DIV_ZERO      = 32'h0000_0000;

    // ------------------------------------------------------------
    // reset values of the registered outputs
    // ------------------------------------------------------------
    localparam logic RST_EXC_VALID = 1'b0;
    localparam logic RST_FLAG      = 1'b0;

    // ------------------------------------------------------------
    // fault reason codes, one per exception kind and sub-kind
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CAUSE_NONE        = 5'h00,
        CAUSE_TRAP        = 5'h01,
        CAUSE_BREAK       = 5'h02,
        CAUSE_UNIMPL      = 5'h03,
        CAUSE_ILLEGAL     = 5'h04,
        CAUSE_SUPER_INSTR = 5'h05,
        CAUSE_SUPER_IADDR = 5'h06,
        CAUSE_SUPER_DADDR = 5'h07,
        CAUSE_MIS_DATA    = 5'h08,
        CAUSE_MIS_DEST    = 5'h09,
        CAUSE_DIV_ERR     = 5'h0A,
        CAUSE_FTLB_INSTR  = 5'h0B,
        CAUSE_FTLB_DATA   = 5'h0C,
        CAUSE_DTLB_INSTR  = 5'h0D,
        CAUSE_DTLB_DATA   = 5'h0E,
        CAUSE_PERM_EXEC   = 5'h0F,
        CAUSE_PERM_READ   = 5'h10,
        CAUSE_PERM_WRITE  = 5'h11,
        CAUSE_MPU_INSTR   = 5'h12,
        CAUSE_MPU_DATA    = 5'h13
    } ied_cause_t;

    // ------------------------------------------------------------
    // handler selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VEC_GENERAL  = 2'h0,
        VEC_FAST_TLB = 2'h1,
        VEC_BREAK    = 2'h2
    } ied_vec_t;

endpackage : ied_pkg

// file: ied_seq_model.sv
// sequencer model: holds the exception handling flag read by the detector
// assumes eh_set is a one-cycle registered pulse on core_clk
`timescale 1ns/100ps
module ied_seq_model (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic eh_set,
    input  wire logic eh_clear,
    output logic      exception_handling_flag
);
    // eh_clear stands for the return from the handler
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            exception_handling_flag <= 1'b0;
        end else if (eh_set) begin
            exception_handling_flag <= 1'b1;
        end else if (eh_clear) begin
            exception_handling_flag <= 1'b0;
        end
    end
endmodule : ied_seq_model

// file: tb.sv
// self-checking bench for the instruction exception detector
// assumes ied_pkg is compiled first; the flag comes from ied_seq_model
`timescale 1ns/100ps
module tb;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        cfg_mmu_present, cfg_mpu_present, cfg_illegal_check_en, cfg_hw_divider;
    logic        cfg_misalign_data_en, cfg_misalign_dest_en, cfg_div_check_en;
    logic        user_mode_flag, exception_handling_flag, eh_clear, issue_valid;
    logic        op_trap, op_break, op_unimpl, op_undefined, op_internal_reserved;
    logic        op_supervisor_only, op_dcache_mgmt, is_load, is_store, is_addr_init;
    logic        is_addr_flush, is_ctrl_xfer, is_divide, div_signed, fetch_super_only;
    logic        fetch_tlb_hit, fetch_tlb_exec_ok, fetch_mpu_hit, fetch_mpu_perm_ok;
    logic        data_super_only, data_tlb_hit, data_tlb_read_ok, data_tlb_write_ok;
    logic        data_mpu_hit, data_mpu_perm_ok, exc_valid, miss_kind_data_flag;
    logic        eh_set, keep_exc_regs, use_normal_regset, exp;
    logic [1:0]  access_size;
    logic [31:0] data_addr, target_addr, dividend, divisor;
    ied_pkg::ied_cause_t fault_reason_field;
    ied_pkg::ied_vec_t   exc_vector;
    int          n_errors = 0;
    int          n_compared = 0;
    integer      seed = 32'h1948fb11;
    // one-hot style stimulus words, see put for the bit order
    logic [22:0] stim_tab [0:19] = '{23'h00_0011, 23'h00_0021, 23'h00_0041, 23'h00_0081,
        23'h00_0181, 23'h00_0080, 23'h00_0084, 23'h00_0082, 23'h00_0209, 23'h00_0201,
        23'h00_2009, 23'h00_200A, 23'h02_0809, 23'h00_8001, 23'h08_0801, 23'h10_1001,
        23'h10_1401, 23'h01_0002, 23'h20_0802, 23'h60_0002};
    ied_pkg::ied_cause_t cause_tab [0:19] = '{ied_pkg::CAUSE_TRAP, ied_pkg::CAUSE_BREAK,
        ied_pkg::CAUSE_UNIMPL, ied_pkg::CAUSE_ILLEGAL, ied_pkg::CAUSE_NONE,
        ied_pkg::CAUSE_NONE, ied_pkg::CAUSE_ILLEGAL, ied_pkg::CAUSE_ILLEGAL,
        ied_pkg::CAUSE_SUPER_INSTR, ied_pkg::CAUSE_NONE, ied_pkg::CAUSE_SUPER_IADDR,
        ied_pkg::CAUSE_NONE, ied_pkg::CAUSE_SUPER_DADDR, ied_pkg::CAUSE_PERM_EXEC,
        ied_pkg::CAUSE_PERM_READ, ied_pkg::CAUSE_PERM_WRITE, ied_pkg::CAUSE_NONE,
        ied_pkg::CAUSE_MPU_INSTR, ied_pkg::CAUSE_MPU_DATA, ied_pkg::CAUSE_MPU_DATA};

    ied_exception_detect dut (.core_clk, .reset, .cfg_mmu_present, .cfg_mpu_present,
        .cfg_illegal_check_en, .cfg_misalign_data_en, .cfg_misalign_dest_en,
        .cfg_div_check_en, .cfg_hw_divider, .user_mode_flag, .exception_handling_flag,
        .issue_valid, .op_trap, .op_break, .op_unimpl, .op_undefined, .op_internal_reserved,
        .op_supervisor_only, .op_dcache_mgmt, .is_load, .is_store, .is_addr_init,
        .is_addr_flush, .access_size, .data_addr, .is_ctrl_xfer, .target_addr, .is_divide,
        .div_signed, .dividend, .divisor, .fetch_super_only, .fetch_tlb_hit,
        .fetch_tlb_exec_ok, .fetch_mpu_hit, .fetch_mpu_perm_ok, .data_super_only,
        .data_tlb_hit, .data_tlb_read_ok, .data_tlb_write_ok, .data_mpu_hit,
        .data_mpu_perm_ok, .exc_valid, .fault_reason_field, .exc_vector,
        .miss_kind_data_flag, .eh_set, .keep_exc_regs, .use_normal_regset);
    ied_seq_model partner (.core_clk, .reset, .eh_set, .eh_clear, .exception_handling_flag);

    always #25 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : cmp

    // lookup-ok bits are inverted so a set bit always means a fault
    task automatic put(input logic [22:0] s);
        {is_addr_init, data_mpu_perm_ok, data_tlb_write_ok, data_tlb_read_ok, data_tlb_hit,
         data_super_only, fetch_mpu_hit, fetch_tlb_exec_ok, fetch_tlb_hit, fetch_super_only,
         is_store, is_load, op_dcache_mgmt, op_supervisor_only, op_internal_reserved,
         op_undefined, op_unimpl, op_break, op_trap, user_mode_flag, cfg_illegal_check_en,
         cfg_mpu_present, cfg_mmu_present} = s ^ 23'h3D_C000;
    endtask : put

    task automatic idle();
        {cfg_misalign_data_en, cfg_misalign_dest_en, is_addr_flush, is_ctrl_xfer} = 4'h0;
        {is_divide, div_signed, eh_clear, data_mpu_hit, fetch_mpu_perm_ok} = 5'h03;
        {cfg_div_check_en, cfg_hw_divider, issue_valid} = 3'h7;
        {data_addr, target_addr, dividend, divisor} = {32'h0000_0000, 96'h0};
        access_size = ied_pkg::ACC_SIZE_WORD;
        put(23'h00_0001);
    endtask : idle

    // issue is taken at the next edge; result is read once that edge settles
    task automatic chk(input ied_pkg::ied_cause_t c, input ied_pkg::ied_vec_t v);
        @(posedge core_clk);
        #5;
        cmp(fault_reason_field, c);
        cmp(exc_vector, v);
        cmp(exc_valid, c != ied_pkg::CAUSE_NONE);
        cmp(use_normal_regset, c != ied_pkg::CAUSE_NONE);
        idle();
    endtask : chk

    function automatic logic mis_exp(input logic [1:0] sz, input logic [31:0] a);
        return (sz == ied_pkg::ACC_SIZE_WORD) ? (a[1:0] != 2'h0) :
               ((sz == ied_pkg::ACC_SIZE_HALF) && a[0]);
    endfunction : mis_exp

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        idle();
        repeat (10) @(posedge core_clk);
        #5;
        cmp({exc_valid, fault_reason_field, exc_vector, eh_set, keep_exc_regs}, 32'h0000_0000);
        cmp({use_normal_regset, miss_kind_data_flag}, 32'h0000_0000);
        reset = 1'b0;
        for (int i = 0; i < 20; i++) begin
            put(stim_tab[i]);
            chk(cause_tab[i], (cause_tab[i] == ied_pkg::CAUSE_BREAK) ? ied_pkg::VEC_BREAK :
                ied_pkg::VEC_GENERAL);
        end
        put(23'h00_4001);
        chk(ied_pkg::CAUSE_FTLB_INSTR, ied_pkg::VEC_FAST_TLB);
        cmp({eh_set, keep_exc_regs, miss_kind_data_flag}, 3'h4);
        @(posedge core_clk);
        #5;
        put(23'h04_0801);
        chk(ied_pkg::CAUSE_DTLB_DATA, ied_pkg::VEC_GENERAL);
        cmp({eh_set, keep_exc_regs, miss_kind_data_flag}, 3'h3);
        put(23'h00_4001);
        chk(ied_pkg::CAUSE_DTLB_INSTR, ied_pkg::VEC_GENERAL);
        cmp(miss_kind_data_flag, 1'b0);
        eh_clear = 1'b1;
        @(posedge core_clk);
        #5;
        put(23'h04_0801);
        chk(ied_pkg::CAUSE_FTLB_DATA, ied_pkg::VEC_FAST_TLB);
        put(23'h00_0011);
        chk(ied_pkg::CAUSE_TRAP, ied_pkg::VEC_GENERAL);
        cmp(miss_kind_data_flag, 1'b1);
        for (int i = 0; i < 32; i++) begin
            put(i[0] ? 23'h00_0801 : 23'h00_0800);
            {cfg_misalign_data_en, cfg_misalign_dest_en} = {i[1], i[3]};
            is_ctrl_xfer = i[2];
            is_load = ~i[2];
            access_size = 2'($unsigned($random(seed)) % 3);
            data_addr = $random(seed);
            target_addr = $random(seed);
            exp = (i[0] || (i[2] ? i[3] : i[1])) && (i[2] ? (target_addr[1:0] != 2'h0) :
                  mis_exp(access_size, data_addr));
            chk(!exp ? ied_pkg::CAUSE_NONE : i[2] ? ied_pkg::CAUSE_MIS_DEST :
                ied_pkg::CAUSE_MIS_DATA, ied_pkg::VEC_GENERAL);
        end
        for (int i = 0; i < 16; i++) begin
            is_divide = 1'b1;
            cfg_hw_divider = (i != 12);
            cfg_div_check_en = (i != 8);
            div_signed = (i % 4 == 1) | 1'($random(seed));
            dividend = (i % 4 == 1) ? ied_pkg::DIV_MOST_NEG : $random(seed);
            divisor = (i % 4 == 0) ? ied_pkg::DIV_ZERO :
                      (i % 4 == 1) ? ied_pkg::DIV_MINUS_ONE : $random(seed);
            exp = cfg_hw_divider && cfg_div_check_en && ((divisor == 32'h0000_0000) ||
                  (div_signed && dividend == 32'h8000_0000 && divisor == 32'hFFFF_FFFF));
            chk(exp ? ied_pkg::CAUSE_DIV_ERR : ied_pkg::CAUSE_NONE,
                ied_pkg::VEC_GENERAL);
        end
        tally_and_finish();
    end

    initial begin
        #100_000;
        n_errors++;
        tally_and_finish();
    end
endmodule : tb
